//--- host_port_pkg.sv
// Shared constants and carrier types for the host bus and peripheral pin port
package host_port_pkg;

  // ----------------------------------------------------------------
  // Clock and frame timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FRAME_HZ = 4_000;
  localparam int unsigned FRAME_CYCLES = CLK_HZ / FRAME_HZ;

  // ----------------------------------------------------------------
  // Register map (five-bit address space)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NUM_REGS = 32;
  localparam logic [4:0] PERIPH_CTRL_ADDR = 5'h10;
  localparam logic [4:0] PERIPH_STAT_ADDR = 5'h11;
  localparam logic [7:0] PERIPH_CTRL_RESET = 8'h80;
  localparam logic [7:0] GENERAL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_LSB = 1;
  localparam int unsigned CTRL_OUT_BIT = 0;
  localparam int unsigned CTRL_IO_VAL_BIT = 1;
  localparam int unsigned CTRL_IO_DIR_BIT = 2;
  localparam int unsigned CTRL_OUT_ALT_BIT = 3;
  localparam int unsigned CTRL_IO_ALT_BIT = 4;
  localparam int unsigned CTRL_INT_EN_BIT = 7;
  localparam int unsigned STAT_CHANGE_BIT = 0;
  localparam int unsigned STAT_IN_A_BIT = 5;
  localparam int unsigned STAT_IN_B_BIT = 6;
  localparam int unsigned STAT_IO_BIT = 7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] ad;
  } host_bus_in_t;

  typedef struct packed {
    logic write;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic io_pin;
    logic in_b;
    logic in_a;
  } aux_samples_t;

endpackage

//--- aux_frame_sampler.sv
// Once-per-frame sampler of the auxiliary inputs with change detection
`timescale 1ns/1ns
module aux_frame_sampler
  import host_port_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Pins and mode
  input wire logic i_aux_in_a,
  input wire logic i_aux_in_b,
  input wire logic i_aux_io_in,
  input wire logic i_io_is_output,
  // Results
  output aux_samples_t o_samples,
  output logic o_change
);

  logic [31:0] frame_count;
  logic frame_tick;
  aux_samples_t next_samples;
  logic differs;

  assign frame_tick = (frame_count == FRAME_LEN - 1);
  // Bidirectional pin keeps its last sample while it is an output
  assign next_samples.in_a = i_aux_in_a;
  assign next_samples.in_b = i_aux_in_b;
  assign next_samples.io_pin = i_io_is_output ? o_samples.io_pin : i_aux_io_in;
  assign differs = (next_samples != o_samples);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      frame_count <= '0;
      o_samples <= '0;
      o_change <= 1'b0;
    end else begin
      frame_count <= frame_tick ? '0 : frame_count + 32'd1;
      o_change <= frame_tick & differs;
      if (frame_tick) begin
        o_samples <= next_samples;
      end
    end
  end

endmodule // aux_frame_sampler

//--- host_bus_peripheral_port.sv
// Multiplexed host bus port, register file and auxiliary pin port
//
// What this block does
// - All timing runs from the one reference clock input.
// - Reset initialises control registers, floats the data, interrupt and bidirectional outputs, and drives the dedicated auxiliary output low.
// - Falling address-latch strobe captures register address from shared bits 1 to 5.
// - Select is latched at that same edge and enables the data phase until its closing strobe edge.
// - Selected read with read strobe low drives the addressed register onto lines.
// - Write data is loaded into the addressed register at the write strobe's rise.
// - Shared lines carry address phase first, then data phase.
// - Interrupt output is open drain, active low, only ever pulled low.
// - Two auxiliary inputs are sampled once per 4 kHz frame into status bits 5, 6.
// - Any sampled input change since last frame raises interrupt; only present values kept.
// - Control bit 2 picks the direction of the bidirectional auxiliary pin.
// - As input, the bidirectional pin is sampled like the others into status bit 7.
// - As output, the bidirectional pin drives control bit 1.
// - Dedicated auxiliary output drives control bit 0 or link status, as selected.
// - Both auxiliary outputs may show subscriber link status instead of register values.
// - On collision the host access goes first; the command access still completes.
// - Every internal register is reachable from the host bus.
`timescale 1ns/1ns
module host_bus_peripheral_port
  import host_port_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Host multiplexed bus
  input host_bus_in_t i_bus,
  output logic [7:0] o_ad_out,
  output logic o_ad_oe_n,
  // Interrupt, open drain
  output logic o_int_out,
  output logic o_int_oe_n,
  // Internal command access
  input wire logic i_cmd_valid,
  input cmd_req_t i_cmd,
  output logic o_cmd_ready,
  output logic o_cmd_done,
  output logic [7:0] o_cmd_rdata,
  // Auxiliary pins
  input wire logic i_aux_in_a,
  input wire logic i_aux_in_b,
  input wire logic i_aux_io_in,
  output logic o_aux_io_out,
  output logic o_aux_io_oe_n,
  output logic o_aux_out_pin,
  // Subscriber link status
  input wire logic i_subscriber_link_status
);

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  logic ale_d;
  logic rd_n_d;
  logic wr_n_d;
  logic ale_fall;
  logic rd_fall;
  logic wr_rise;

  assign ale_fall = ale_d & ~i_bus.ale;
  assign rd_fall = rd_n_d & ~i_bus.rd_n;
  assign wr_rise = ~wr_n_d & i_bus.wr_n;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ale_d <= 1'b0;
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
    end else begin
      ale_d <= i_bus.ale;
      rd_n_d <= i_bus.rd_n;
      wr_n_d <= i_bus.wr_n;
    end
  end

  // ----------------------------------------------------------------
  // Address phase
  // ----------------------------------------------------------------
  logic [4:0] addr;
  logic selected;
  logic [7:0] wr_data;
  logic cycle_end;

  // Select covers exactly one data phase, ending at the closing strobe edge
  assign cycle_end = wr_rise | (~rd_n_d & i_bus.rd_n);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr <= '0;
      selected <= 1'b0;
      wr_data <= '0;
    end else begin
      if (ale_fall) begin
        addr <= i_bus.ad[ADDR_LSB +: ADDR_W];
        selected <= ~i_bus.cs_n;
      end else if (cycle_end) begin
        selected <= 1'b0;
      end
      // Data captured while the strobe is low; the rising edge sees the last value
      if (~i_bus.wr_n) begin
        wr_data <= i_bus.ad;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command access arbitration
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_HELD = 1'b1
  } cmd_state_t;

  cmd_state_t cmd_state;
  cmd_state_t next_cmd_state;
  cmd_req_t cmd_held;
  logic cmd_take;
  logic host_write;
  logic host_read;
  logic host_busy;
  logic cmd_go;

  assign cmd_take = i_cmd_valid & o_cmd_ready;
  assign host_write = wr_rise & selected;
  assign host_read = rd_fall & selected;
  // Host strobes win the register port; the held command just waits a cycle
  assign host_busy = host_write | host_read;
  assign cmd_go = (cmd_state == CMD_HELD) & ~host_busy;

  always_comb begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      CMD_IDLE: begin
        if (cmd_take) begin
          next_cmd_state = CMD_HELD;
        end
      end
      CMD_HELD: begin
        if (cmd_go) begin
          next_cmd_state = CMD_IDLE;
        end
      end
      default: begin
        next_cmd_state = CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cmd_state <= CMD_IDLE;
      o_cmd_ready <= 1'b0;
      o_cmd_done <= 1'b0;
    end else begin
      cmd_state <= next_cmd_state;
      o_cmd_ready <= (cmd_state == CMD_IDLE) & ~cmd_take;
      o_cmd_done <= cmd_go;
    end
  end

  // Copied only when taken, so the request stays still while it waits
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cmd_held <= '0;
    end else if (cmd_take) begin
      cmd_held <= i_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs [NUM_REGS];
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_value;
  logic [7:0] ctrl;
  logic [7:0] status;
  aux_samples_t samples;
  logic change_flag;
  logic sample_change;

  // Host write takes the port first; command write waits one cycle
  assign wr_en = host_write | (cmd_go & cmd_held.write);
  assign wr_addr = host_write ? addr : cmd_held.addr;
  assign wr_value = host_write ? wr_data : cmd_held.wdata;
  assign ctrl = regs[PERIPH_CTRL_ADDR];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      localparam logic [7:0] RST = (IDX == PERIPH_CTRL_ADDR) ? PERIPH_CTRL_RESET
                                                              : GENERAL_RESET;
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          regs[gi] <= RST;
        end else if (wr_en && wr_addr == IDX && IDX != PERIPH_STAT_ADDR) begin
          regs[gi] <= wr_value;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status and auxiliary sampling
  // ----------------------------------------------------------------
  aux_frame_sampler #(
    .FRAME_LEN(FRAME_LEN)
  ) u_sampler (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_aux_in_a(i_aux_in_a),
    .i_aux_in_b(i_aux_in_b),
    .i_aux_io_in(i_aux_io_in),
    .i_io_is_output(ctrl[CTRL_IO_DIR_BIT]),
    .o_samples(samples),
    .o_change(sample_change)
  );

  always_comb begin
    status = '0;
    status[STAT_CHANGE_BIT] = change_flag;
    status[STAT_IN_A_BIT] = samples.in_a;
    status[STAT_IN_B_BIT] = samples.in_b;
    status[STAT_IO_BIT] = samples.io_pin;
  end

  logic stat_read;
  logic [7:0] host_rdata;
  logic [7:0] cmd_rdata;

  // A host read of the status register acknowledges the change event
  assign stat_read = rd_fall & selected & (addr == PERIPH_STAT_ADDR);
  assign host_rdata = (addr == PERIPH_STAT_ADDR) ? status : regs[addr];
  assign cmd_rdata = (cmd_held.addr == PERIPH_STAT_ADDR) ? status : regs[cmd_held.addr];

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      change_flag <= 1'b0;
    end else if (sample_change) begin
      change_flag <= 1'b1;
    end else if (stat_read) begin
      change_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  logic next_io_val;
  logic next_out_val;

  assign next_io_val = ctrl[CTRL_IO_ALT_BIT] ? i_subscriber_link_status
                                             : ctrl[CTRL_IO_VAL_BIT];
  assign next_out_val = ctrl[CTRL_OUT_ALT_BIT] ? i_subscriber_link_status
                                               : ctrl[CTRL_OUT_BIT];

  // Data refreshes every cycle; only the enable decides who owns the lines
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ad_out <= '0;
      o_ad_oe_n <= 1'b1;
    end else begin
      o_ad_out <= host_rdata;
      o_ad_oe_n <= ~(selected & ~i_bus.rd_n);
    end
  end

  // Open drain: level tied low, only the enable moves
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_int_out <= 1'b0;
      o_int_oe_n <= 1'b1;
    end else begin
      o_int_out <= 1'b0;
      o_int_oe_n <= ~(change_flag & ctrl[CTRL_INT_EN_BIT]);
    end
  end

  // Auxiliary pins follow the control register one cycle late
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_aux_io_out <= 1'b0;
      o_aux_io_oe_n <= 1'b1;
      o_aux_out_pin <= 1'b0;
    end else begin
      o_aux_io_out <= next_io_val;
      o_aux_io_oe_n <= ~ctrl[CTRL_IO_DIR_BIT];
      o_aux_out_pin <= next_out_val;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_cmd_rdata <= '0;
    end else if (cmd_go) begin
      o_cmd_rdata <= cmd_rdata;
    end
  end

endmodule // host_bus_peripheral_port

//--- host_bus_peripheral_port_checker.sv
// Concurrent assertions for the host bus and peripheral pin port
`timescale 1ns/1ns
module host_bus_peripheral_port_checker
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Watched ports
  input host_bus_in_t i_bus,
  input wire logic o_ad_oe_n,
  input wire logic o_int_out,
  input wire logic o_int_oe_n,
  input wire logic i_cmd_valid,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_done,
  input wire logic o_aux_io_oe_n,
  input wire logic o_aux_out_pin
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // Own copy of the latched select, so drive checks need no design internals
  logic ale_d;
  logic sel;
  always_ff @(posedge i_ref_clk) begin
    ale_d <= i_bus.ale;
    if (i_reset) begin
      sel <= 1'b0;
    end else if (ale_d && !i_bus.ale) begin
      sel <= !i_bus.cs_n;
    end else if ($rose(i_bus.rd_n) || $rose(i_bus.wr_n)) begin
      sel <= 1'b0;
    end
  end

  int_never_high_a: assert property (o_int_out == 1'b0)
    else $error("interrupt pin driven high");
  reset_float_a: assert property (disable iff (1'b0)
    i_reset |=> o_ad_oe_n && o_int_oe_n && o_aux_io_oe_n && !o_aux_out_pin)
    else $error("outputs not released in reset");
  read_drive_a: assert property (sel && !i_bus.rd_n |=> !o_ad_oe_n)
    else $error("selected read not driven");
  read_cause_a: assert property (!o_ad_oe_n |-> sel && !$past(i_bus.rd_n))
    else $error("data lines driven without selected read");
  read_stop_a: assert property ($rose(i_bus.rd_n) |=> o_ad_oe_n)
    else $error("data lines not released");
  read_hold_a: assert property (!o_ad_oe_n && !i_bus.rd_n |=> !o_ad_oe_n)
    else $error("read drive dropped early");
  cmd_take_a: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
    else $error("command not held");
  cmd_done_a: assert property (i_cmd_valid && o_cmd_ready |-> ##[2:8] o_cmd_done)
    else $error("command never completed");
  done_pulse_a: assert property (o_cmd_done |=> !o_cmd_done)
    else $error("done longer than one cycle");
endmodule // host_bus_peripheral_port_checker

bind host_bus_peripheral_port host_bus_peripheral_port_checker u_checker (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(i_bus), .o_ad_oe_n(o_ad_oe_n),
  .o_int_out(o_int_out), .o_int_oe_n(o_int_oe_n), .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done), .o_aux_io_oe_n(o_aux_io_oe_n),
  .o_aux_out_pin(o_aux_out_pin));

//--- host_cpu_model.sv
// Local microcontroller model on the multiplexed address/data bus
`timescale 1ns/1ns
module host_cpu_model
  import host_port_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Resolved data lines and bus strobes
  input wire logic [7:0] i_ad_wire,
  output host_bus_in_t o_bus
);
  initial o_bus = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00};

  // Bits 0, 6 and 7 set on purpose so a sloppy decode shows up
  task automatic addr_phase(input logic [4:0] a, input logic cs_n);
    @(posedge i_ref_clk) #1;
    o_bus.ale = 1'b1;
    o_bus.cs_n = cs_n;
    o_bus.ad = {2'b11, a, 1'b1};
    @(posedge i_ref_clk) #1;
    o_bus.ale = 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic cs_n);
    addr_phase(a, cs_n);
    @(posedge i_ref_clk) #1;
    o_bus.wr_n = 1'b0;
    o_bus.ad = d;
    @(posedge i_ref_clk) #1;
    o_bus.wr_n = 1'b1;
    o_bus.cs_n = 1'b1;
    o_bus.ad = ~d;
    @(posedge i_ref_clk) #1;
  endtask

  // Released lines show the inverse, never the stale address
  task automatic rd(input logic [4:0] a, output logic [7:0] d, input logic cs_n);
    addr_phase(a, cs_n);
    @(posedge i_ref_clk) #1;
    o_bus.rd_n = 1'b0;
    o_bus.ad = ~o_bus.ad;
    repeat (2) @(posedge i_ref_clk);
    d = i_ad_wire;
    #1;
    o_bus.rd_n = 1'b1;
    o_bus.cs_n = 1'b1;
    @(posedge i_ref_clk) #1;
  endtask
endmodule // host_cpu_model

//--- tb_host_bus_peripheral_port.sv
// Self-checking testbench for the host bus and peripheral pin port
`timescale 1ns/1ns
module tb_host_bus_peripheral_port;
  import host_port_pkg::*;
  localparam int unsigned FRAME = 16;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  host_bus_in_t cpu_bus;
  host_bus_in_t dut_bus;
  logic [7:0] ad_wire, o_ad_out, o_cmd_rdata, rdata;
  logic o_ad_oe_n, o_int_out, o_int_oe_n, o_cmd_ready, o_cmd_done;
  logic o_aux_io_out, o_aux_io_oe_n, o_aux_out_pin;
  logic cmd_valid = 1'b0;
  cmd_req_t cmd = '0;
  logic in_a = 1'b0, in_b = 1'b0, io_in = 1'b0, link = 1'b0;
  logic [4:0] addrs [4] = '{5'h02, 5'h12, 5'h09, 5'h1f};
  int error_cnt = 0;
  int tests_run = 0;

  always #4 i_ref_clk = ~i_ref_clk;
  assign ad_wire = o_ad_oe_n ? cpu_bus.ad : o_ad_out;
  assign dut_bus = {cpu_bus[11:8], ad_wire};

  host_cpu_model u_cpu (.i_ref_clk(i_ref_clk), .i_ad_wire(ad_wire), .o_bus(cpu_bus));
  host_bus_peripheral_port #(.FRAME_LEN(FRAME)) u_dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(dut_bus), .o_ad_out(o_ad_out),
    .o_ad_oe_n(o_ad_oe_n), .o_int_out(o_int_out), .o_int_oe_n(o_int_oe_n),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(o_cmd_ready),
    .o_cmd_done(o_cmd_done), .o_cmd_rdata(o_cmd_rdata), .i_aux_in_a(in_a),
    .i_aux_in_b(in_b), .i_aux_io_in(io_in), .o_aux_io_out(o_aux_io_out),
    .o_aux_io_oe_n(o_aux_io_oe_n), .o_aux_out_pin(o_aux_out_pin),
    .i_subscriber_link_status(link));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_check(input logic [4:0] a, input logic [7:0] exp);
    u_cpu.rd(a, rdata, 1'b0);
    check(rdata, exp);
  endtask

  task automatic pins_check(input logic [2:0] exp);
    @(posedge i_ref_clk) #1;
    check({5'h00, o_aux_io_oe_n, o_aux_io_out, o_aux_out_pin}, {5'h00, exp});
  endtask

  task automatic cmd_run(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge i_ref_clk) #1;
    cmd_valid = 1'b1;
    cmd = '{w, a, d};
    while (n < 20 && o_cmd_ready !== 1'b1) begin
      @(posedge i_ref_clk) #1;
      n++;
    end
    @(posedge i_ref_clk) #1;
    cmd_valid = 1'b0;
    while (n < 40 && o_cmd_done !== 1'b1) begin
      @(posedge i_ref_clk) #1;
      n++;
    end
    if (o_cmd_done !== 1'b1) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, o_cmd_done, 1'b1);
      print_verdict();
    end
  endtask

  initial begin
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_reset = 1'b0;
    check({5'h00, o_ad_oe_n, o_int_oe_n, o_aux_io_oe_n}, 8'h07);
    reg_check(PERIPH_CTRL_ADDR, PERIPH_CTRL_RESET);
    reg_check(5'h05, GENERAL_RESET);
    $display("test reset done");
    // Pairs 02/12 alias if the wrong address bits are decoded
    for (int i = 0; i < 4; i++) u_cpu.wr(addrs[i], 8'(8'h5a ^ i), 1'b0);
    for (int i = 0; i < 4; i++) reg_check(addrs[i], 8'(8'h5a ^ i));
    u_cpu.wr(5'h02, 8'h3c, 1'b1);
    u_cpu.rd(5'h02, rdata, 1'b1);
    check(rdata, 8'h3a);
    reg_check(5'h02, 8'h5a);
    $display("test bus access done");
    u_cpu.wr(PERIPH_CTRL_ADDR, 8'h86, 1'b0);
    pins_check(3'h2);
    u_cpu.wr(PERIPH_CTRL_ADDR, 8'h9c, 1'b0);
    for (int i = 0; i < 2; i++) begin
      link = i[0];
      repeat (2) @(posedge i_ref_clk);
      pins_check({1'b0, {2{i[0]}}});
    end
    reg_check(PERIPH_CTRL_ADDR, 8'h9c);
    $display("test aux outputs done");
    u_cpu.wr(PERIPH_CTRL_ADDR, 8'h80, 1'b0);
    in_a = 1'b1;
    io_in = 1'b1;
    repeat (2 * FRAME + 4) @(posedge i_ref_clk);
    check({6'h00, o_int_out, o_int_oe_n}, 8'h00);
    reg_check(PERIPH_STAT_ADDR, 8'ha1);
    check({7'h00, o_int_oe_n}, 8'h01);
    u_cpu.wr(PERIPH_STAT_ADDR, 8'hff, 1'b0);
    reg_check(PERIPH_STAT_ADDR, 8'ha0);
    u_cpu.wr(PERIPH_CTRL_ADDR, 8'h00, 1'b0);
    in_b = 1'b1;
    repeat (2 * FRAME + 4) @(posedge i_ref_clk);
    check({7'h00, o_int_oe_n}, 8'h01);
    reg_check(PERIPH_STAT_ADDR, 8'he1);
    $display("test aux sampling done");
    cmd_run(1'b1, 5'h07, 8'h69);
    // Command lands on the edge of the host write commit
    fork
      u_cpu.wr(5'h08, 8'h11, 1'b0);
      begin
        repeat (2) @(posedge i_ref_clk);
        cmd_run(1'b1, 5'h09, 8'h22);
      end
    join
    reg_check(5'h07, 8'h69);
    reg_check(5'h08, 8'h11);
    reg_check(5'h09, 8'h22);
    cmd_run(1'b0, 5'h12, 8'h00);
    check(o_cmd_rdata, 8'h5b);
    $display("test command access done");
    print_verdict();
  end
endmodule // tb_host_bus_peripheral_port
